/* File: src/crm_cfg.svh */
`ifndef CRM_CFG_SVH
`define CRM_CFG_SVH
// control tokens
`define CRM_TOK_WR    8'hC0
`define CRM_TOK_RD    8'hC1
`define CRM_TOK_PWR   8'h24
`define CRM_TOK_PRD   8'h25
`define CRM_TOK_END   8'h01
`define CRM_TOK_ACK   8'h03
`define CRM_TOK_NAK   8'h04
// return field and suppression
`define CRM_RET_LAST  8'h02
`define CRM_SUP_LOW   8'hFF
// destination suffixes
`define CRM_TILE_SFX  16'hC20C
`define CRM_NODE_SFX  16'hC30C
`define CRM_PER_SFX   8'h02
// field lengths, last byte index
`define CRM_WREG_LAST 8'h01
`define CRM_WORD_LAST 8'h03
`define CRM_WORD_LEN  8'h04
// processor-status resource id; longest request message
`define CRM_PS_LOW    8'h0B
`define CRM_PS_SHIFT  8
`define CRM_MSG_MAX   11
`endif

/* File: src/crm_pkg.sv */
package crm_pkg;
   typedef enum logic [1:0] {
      TGT_NONE = 2'b00,
      TGT_TILE = 2'b01,
      TGT_NODE = 2'b10,
      TGT_PER  = 2'b11
   } crm_tgt_t;

   typedef enum logic [3:0] {
      D_IDLE  = 4'b0000,
      D_RET   = 4'b0001,
      D_REG   = 4'b0010,
      D_SIZE  = 4'b0011,
      D_DATA  = 4'b0100,
      D_END   = 4'b0101,
      D_DRAIN = 4'b0110,
      D_RHDR  = 4'b0111,
      D_RDAT  = 4'b1000,
      D_REND  = 4'b1001
   } crm_dst_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_WAIT = 2'b10,
      H_RDAT = 2'b11
   } crm_hst_t;
endpackage : crm_pkg

/* File: src/crm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface crm_if;
   logic        req_valid;
   logic        req_ready;
   logic        req_ctrl;
   logic [7:0]  req_byte;
   logic [31:0] req_dest;
   logic        rsp_valid;
   logic        rsp_ready;
   logic        rsp_ctrl;
   logic [7:0]  rsp_byte;
   logic [23:0] rsp_dest;

   modport dev (
      input  req_valid, req_ctrl, req_byte, req_dest, rsp_ready,
      output req_ready, rsp_valid, rsp_ctrl, rsp_byte, rsp_dest
   );
   modport host (
      output req_valid, req_ctrl, req_byte, req_dest, rsp_ready,
      input  req_ready, rsp_valid, rsp_ctrl, rsp_byte, rsp_dest
   );
endinterface : crm_if
`default_nettype wire

/* File: src/crm_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crm_cfg.svh"
module crm_dev #(
   parameter int          NREG      = 16,
   parameter int          PREG      = 16,
   parameter logic [15:0] TILE_ID   = 16'h0001, // arbitrary
   parameter logic [15:0] NODE_ID   = 16'h0002, // arbitrary
   parameter logic [7:0]  PERIPH_ID = 8'h03     // arbitrary
) (
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   crm_if.dev               LNK,
   output logic             WR_STB,
   output logic [1:0]       WR_TGT,
   output logic [15:0]      WR_REG,
   output logic [31:0]      WR_DATA
);
   localparam int AW  = (NREG > 1) ? $clog2(NREG) : 1;
   localparam int PAW = (PREG > 1) ? $clog2(PREG) : 1;

   crm_pkg::crm_dst_t state_r;
   crm_pkg::crm_tgt_t tgt_r;
   crm_pkg::crm_tgt_t dest_tgt;
   logic              is_wr_r;
   logic              err_r;
   logic [23:0]       ret_r;
   logic [15:0]       reg_r;
   logic [7:0]        size_r;
   logic [31:0]       dat_r;
   logic [7:0]        cnt_r;
   logic [7:0]        rsp_n_r;
   logic              rsp_ctrl_r;
   logic [7:0]        rsp_byte_r;
   logic [31:0]       tile_mem [NREG];
   logic [31:0]       node_mem [NREG];
   logic [7:0]        per_mem  [PREG];

   logic        take;
   logic        is_end;
   logic        per;
   logic        suppress;
   logic        fin;
   logic        fin_ok;
   logic        op_ok;
   logic [15:0] reg_nxt;
   logic [7:0]  reg_last;
   logic [7:0]  data_last;
   logic [8:0]  size_end;
   logic [7:0]  rd_cnt;
   logic [7:0]  per_rd;
   logic [31:0] word_rd;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   always_comb begin
      dest_tgt = crm_pkg::TGT_NONE;
      if (LNK.req_dest == {TILE_ID, `CRM_TILE_SFX})
         dest_tgt = crm_pkg::TGT_TILE;
      else if (LNK.req_dest == {NODE_ID, `CRM_NODE_SFX})
         dest_tgt = crm_pkg::TGT_NODE;
      else if (LNK.req_dest == {NODE_ID, PERIPH_ID, `CRM_PER_SFX})
         dest_tgt = crm_pkg::TGT_PER;
   end

   assign op_ok = ((LNK.req_byte == `CRM_TOK_WR || LNK.req_byte == `CRM_TOK_RD)
                   && (dest_tgt == crm_pkg::TGT_TILE || dest_tgt == crm_pkg::TGT_NODE))
               || ((LNK.req_byte == `CRM_TOK_PWR || LNK.req_byte == `CRM_TOK_PRD)
                   && dest_tgt == crm_pkg::TGT_PER);

   assign LNK.req_ready = (state_r == crm_pkg::D_IDLE) || (state_r == crm_pkg::D_RET)
                       || (state_r == crm_pkg::D_REG) || (state_r == crm_pkg::D_SIZE)
                       || (state_r == crm_pkg::D_DATA) || (state_r == crm_pkg::D_END)
                       || (state_r == crm_pkg::D_DRAIN);
   assign LNK.rsp_valid = (state_r == crm_pkg::D_RHDR) || (state_r == crm_pkg::D_RDAT)
                       || (state_r == crm_pkg::D_REND);
   assign LNK.rsp_ctrl  = rsp_ctrl_r;
   assign LNK.rsp_byte  = rsp_byte_r;
   assign LNK.rsp_dest  = ret_r;

   assign take      = LNK.req_valid && LNK.req_ready;
   assign is_end    = LNK.req_ctrl && (LNK.req_byte == `CRM_TOK_END);
   assign per       = (tgt_r == crm_pkg::TGT_PER);
   assign suppress  = is_wr_r && (ret_r[7:0] == `CRM_SUP_LOW);
   // a closing token only counts once the return address is complete
   assign fin       = take && is_end && (state_r != crm_pkg::D_IDLE)
                    && (state_r != crm_pkg::D_RET);
   assign fin_ok    = fin && (state_r == crm_pkg::D_END) && !err_r;
   assign reg_nxt   = per ? {8'h00, LNK.req_byte} : {reg_r[7:0], LNK.req_byte};
   assign reg_last  = per ? 8'h00 : `CRM_WREG_LAST;
   assign data_last = per ? (size_r - 8'h01) : `CRM_WORD_LAST;
   assign size_end  = {1'b0, reg_r[7:0]} + {1'b0, LNK.req_byte};
   assign rd_cnt    = (state_r == crm_pkg::D_RHDR) ? 8'h00 : (cnt_r + 8'h01);
   assign per_rd    = per_mem[PAW'(reg_r[7:0] + rd_cnt)];
   assign word_rd   = (tgt_r == crm_pkg::TGT_TILE) ? tile_mem[AW'(reg_r)] : node_mem[AW'(reg_r)];

   ////////////////////////////////////////////////////////////////////////////
   // message parser and reply sequencer
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r    <= crm_pkg::D_IDLE;
         tgt_r      <= crm_pkg::TGT_NONE;
         is_wr_r    <= 1'b0;
         err_r      <= 1'b0;
         ret_r      <= 24'h000000;
         reg_r      <= 16'h0000;
         size_r     <= 8'h00;
         dat_r      <= 32'h00000000;
         cnt_r      <= 8'h00;
         rsp_n_r    <= 8'h00;
         rsp_ctrl_r <= 1'b0;
         rsp_byte_r <= 8'h00;
      end else if (fin) begin
         err_r <= !fin_ok;
         cnt_r <= 8'h00;
         if (suppress) begin
            state_r <= crm_pkg::D_IDLE;
         end else begin
            state_r    <= crm_pkg::D_RHDR;
            rsp_ctrl_r <= 1'b1;
            rsp_byte_r <= fin_ok ? `CRM_TOK_ACK : `CRM_TOK_NAK;
            rsp_n_r    <= (fin_ok && !is_wr_r) ? (per ? size_r : `CRM_WORD_LEN) : 8'h00;
            if (fin_ok && !is_wr_r && !per)
               dat_r <= word_rd;
         end
      end else begin
         unique case (state_r)
            crm_pkg::D_IDLE: begin
               // stray data or lone closers before a header are dropped
               if (take && LNK.req_ctrl && !is_end) begin
                  is_wr_r <= (LNK.req_byte == `CRM_TOK_WR) || (LNK.req_byte == `CRM_TOK_PWR);
                  tgt_r   <= dest_tgt;
                  err_r   <= !op_ok;
                  cnt_r   <= 8'h00;
                  state_r <= crm_pkg::D_RET;
               end
            end
            crm_pkg::D_RET: begin
               if (take && LNK.req_ctrl) begin
                  // no return address yet, so nobody to answer
                  state_r <= crm_pkg::D_IDLE;
               end else if (take) begin
                  ret_r <= {ret_r[15:0], LNK.req_byte};
                  if (cnt_r == `CRM_RET_LAST) begin
                     cnt_r   <= 8'h00;
                     state_r <= err_r ? crm_pkg::D_DRAIN : crm_pkg::D_REG;
                  end else begin
                     cnt_r <= cnt_r + 8'h01;
                  end
               end
            end
            crm_pkg::D_REG: begin
               if (take && LNK.req_ctrl) begin
                  err_r   <= 1'b1;
                  state_r <= crm_pkg::D_DRAIN;
               end else if (take) begin
                  reg_r <= reg_nxt;
                  if (cnt_r == reg_last) begin
                     cnt_r <= 8'h00;
                     if (per)
                        state_r <= crm_pkg::D_SIZE;
                     else if (reg_nxt >= 16'(NREG)) begin
                        err_r   <= 1'b1;
                        state_r <= crm_pkg::D_DRAIN;
                     end else
                        state_r <= is_wr_r ? crm_pkg::D_DATA : crm_pkg::D_END;
                  end else begin
                     cnt_r <= cnt_r + 8'h01;
                  end
               end
            end
            crm_pkg::D_SIZE: begin
               if (take && LNK.req_ctrl) begin
                  err_r   <= 1'b1;
                  state_r <= crm_pkg::D_DRAIN;
               end else if (take) begin
                  size_r <= LNK.req_byte;
                  if (LNK.req_byte == 8'h00 || size_end > 9'(PREG)) begin
                     err_r   <= 1'b1;
                     state_r <= crm_pkg::D_DRAIN;
                  end else
                     state_r <= is_wr_r ? crm_pkg::D_DATA : crm_pkg::D_END;
               end
            end
            crm_pkg::D_DATA: begin
               if (take && LNK.req_ctrl) begin
                  err_r   <= 1'b1;
                  state_r <= crm_pkg::D_DRAIN;
               end else if (take) begin
                  dat_r <= {dat_r[23:0], LNK.req_byte};
                  if (cnt_r == data_last) begin
                     cnt_r   <= 8'h00;
                     state_r <= crm_pkg::D_END;
                  end else begin
                     cnt_r <= cnt_r + 8'h01;
                  end
               end
            end
            crm_pkg::D_END: begin
               if (take) begin
                  err_r   <= 1'b1;
                  state_r <= crm_pkg::D_DRAIN;
               end
            end
            crm_pkg::D_DRAIN: begin
               // waits for the closing token, handled above
            end
            crm_pkg::D_RHDR: begin
               if (LNK.rsp_ready) begin
                  if (rsp_n_r != 8'h00) begin
                     state_r    <= crm_pkg::D_RDAT;
                     rsp_ctrl_r <= 1'b0;
                     rsp_byte_r <= per ? per_rd : dat_r[31:24];
                     dat_r      <= {dat_r[23:0], 8'h00};
                  end else begin
                     state_r    <= crm_pkg::D_REND;
                     rsp_byte_r <= `CRM_TOK_END;
                  end
               end
            end
            crm_pkg::D_RDAT: begin
               if (LNK.rsp_ready) begin
                  cnt_r <= cnt_r + 8'h01;
                  if (cnt_r + 8'h01 == rsp_n_r) begin
                     state_r    <= crm_pkg::D_REND;
                     rsp_ctrl_r <= 1'b1;
                     rsp_byte_r <= `CRM_TOK_END;
                  end else begin
                     rsp_byte_r <= per ? per_rd : dat_r[31:24];
                     dat_r      <= {dat_r[23:0], 8'h00};
                  end
               end
            end
            crm_pkg::D_REND: begin
               if (LNK.rsp_ready)
                  state_r <= crm_pkg::D_IDLE;
            end
            default: state_r <= crm_pkg::D_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register storage; word writes commit only on a clean close
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < NREG; i++) begin
            tile_mem[i] <= 32'h00000000;
            node_mem[i] <= 32'h00000000;
         end
      end else if (fin_ok && is_wr_r && !per) begin
         if (tgt_r == crm_pkg::TGT_TILE)
            tile_mem[AW'(reg_r)] <= dat_r;
         else
            node_mem[AW'(reg_r)] <= dat_r;
      end
   end

   // peripheral bytes land as they arrive; range was checked on the size byte
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < PREG; i++)
            per_mem[i] <= 8'h00;
      end else if (take && !LNK.req_ctrl && state_r == crm_pkg::D_DATA && per && !err_r) begin
         per_mem[PAW'(reg_r[7:0] + cnt_r)] <= LNK.req_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // user-side write notification
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         WR_STB  <= 1'b0;
         WR_TGT  <= 2'b00;
         WR_REG  <= 16'h0000;
         WR_DATA <= 32'h00000000;
      end else if (fin_ok && is_wr_r && !per) begin
         WR_STB  <= 1'b1;
         WR_TGT  <= tgt_r;
         WR_REG  <= reg_r;
         WR_DATA <= dat_r;
      end else if (take && !LNK.req_ctrl && state_r == crm_pkg::D_DATA && per && !err_r) begin
         WR_STB  <= 1'b1;
         WR_TGT  <= tgt_r;
         WR_REG  <= {8'h00, reg_r[7:0] + cnt_r};
         WR_DATA <= {24'h000000, LNK.req_byte};
      end else begin
         WR_STB <= 1'b0;
      end
   end
endmodule : crm_dev
`default_nettype wire

/* File: src/crm_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crm_cfg.svh"
module crm_host (
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   crm_if.host              LNK,
   input  wire logic        CMD_VALID,
   output logic             CMD_READY,
   input  wire logic        CMD_WR,
   input  wire logic [1:0]  CMD_TGT,
   input  wire logic [15:0] CMD_ID,
   input  wire logic [7:0]  CMD_PER,
   input  wire logic [23:0] CMD_RET,
   input  wire logic [15:0] CMD_REG,
   input  wire logic [7:0]  CMD_SIZE,
   input  wire logic [31:0] CMD_DATA,
   output logic             RES_VALID,
   output logic             RES_OK,
   output logic [31:0]      RES_DATA,
   input  wire logic [23:0] PS_REG,
   output logic [31:0]      PS_ID
);
   crm_pkg::crm_hst_t state_r;
   logic [8:0]        sh_r [`CRM_MSG_MAX];
   logic [8:0]        msg  [`CRM_MSG_MAX];
   logic [3:0]        rem_r;
   logic [3:0]        len;
   logic [31:0]       dest_r;
   logic [23:0]       ret_r;
   logic              sup_r;
   logic              ok_r;
   logic              per;
   logic [2:0]        nbytes;
   logic [31:0]       dsh;
   logic              rsp_take;

   assign per       = (CMD_TGT == crm_pkg::TGT_PER);
   assign nbytes    = (CMD_SIZE > 8'h04) ? 3'd4 : CMD_SIZE[2:0];
   // short peripheral writes send the low bytes of the word
   assign dsh       = per ? (CMD_DATA << (6'd32 - {nbytes, 3'b000})) : CMD_DATA;
   assign CMD_READY = (state_r == crm_pkg::H_IDLE);
   assign LNK.req_valid = (state_r == crm_pkg::H_SEND);
   assign LNK.req_ctrl  = sh_r[0][8];
   assign LNK.req_byte  = sh_r[0][7:0];
   assign LNK.req_dest  = dest_r;
   assign LNK.rsp_ready = (state_r == crm_pkg::H_WAIT) || (state_r == crm_pkg::H_RDAT);
   assign rsp_take = LNK.rsp_valid && LNK.rsp_ready && (LNK.rsp_dest == ret_r);

   ////////////////////////////////////////////////////////////////////////////
   // message assembly, token first, fields most significant byte first
   always_comb begin
      int n;
      n = 0;
      for (int i = 0; i < `CRM_MSG_MAX; i++)
         msg[i] = 9'h000;
      if (per)
         msg[0] = {1'b1, CMD_WR ? `CRM_TOK_PWR : `CRM_TOK_PRD};
      else
         msg[0] = {1'b1, CMD_WR ? `CRM_TOK_WR : `CRM_TOK_RD};
      msg[1] = {1'b0, CMD_RET[23:16]};
      msg[2] = {1'b0, CMD_RET[15:8]};
      msg[3] = {1'b0, CMD_RET[7:0]};
      msg[4] = {1'b0, per ? CMD_REG[7:0] : CMD_REG[15:8]};
      msg[5] = {1'b0, per ? CMD_SIZE : CMD_REG[7:0]};
      n = 6;
      if (CMD_WR) begin
         for (int i = 0; i < 4; i++) begin
            if (!per || i < int'(nbytes)) begin
               msg[n] = {1'b0, dsh[31 - 8*i -: 8]};
               n = n + 1;
            end
         end
      end
      msg[n] = {1'b1, `CRM_TOK_END};
      len = 4'(n + 1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // request sender and reply collector
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r  <= crm_pkg::H_IDLE;
         for (int i = 0; i < `CRM_MSG_MAX; i++)
            sh_r[i] <= 9'h000;
         rem_r    <= 4'h0;
         dest_r   <= 32'h00000000;
         ret_r    <= 24'h000000;
         sup_r    <= 1'b0;
         ok_r     <= 1'b0;
         RES_VALID <= 1'b0;
         RES_OK   <= 1'b0;
         RES_DATA <= 32'h00000000;
      end else begin
         RES_VALID <= 1'b0;
         unique case (state_r)
            crm_pkg::H_IDLE: begin
               if (CMD_VALID) begin
                  sh_r    <= msg;
                  rem_r   <= len;
                  ret_r   <= CMD_RET;
                  sup_r   <= CMD_WR && (CMD_RET[7:0] == `CRM_SUP_LOW);
                  state_r <= crm_pkg::H_SEND;
                  if (CMD_TGT == crm_pkg::TGT_TILE)
                     dest_r <= {CMD_ID, `CRM_TILE_SFX};
                  else if (CMD_TGT == crm_pkg::TGT_NODE)
                     dest_r <= {CMD_ID, `CRM_NODE_SFX};
                  else
                     dest_r <= {CMD_ID, CMD_PER, `CRM_PER_SFX};
               end
            end
            crm_pkg::H_SEND: begin
               if (LNK.req_ready) begin
                  for (int i = 0; i < `CRM_MSG_MAX - 1; i++)
                     sh_r[i] <= sh_r[i + 1];
                  sh_r[`CRM_MSG_MAX - 1] <= 9'h000;
                  rem_r <= rem_r - 4'h1;
                  if (rem_r == 4'h1) begin
                     if (sup_r) begin
                        // suppressed write: nothing will come back
                        RES_VALID <= 1'b1;
                        RES_OK    <= 1'b1;
                        state_r   <= crm_pkg::H_IDLE;
                     end else
                        state_r <= crm_pkg::H_WAIT;
                  end
               end
            end
            crm_pkg::H_WAIT: begin
               if (rsp_take && LNK.rsp_ctrl) begin
                  ok_r     <= (LNK.rsp_byte == `CRM_TOK_ACK);
                  RES_DATA <= 32'h00000000;
                  state_r  <= crm_pkg::H_RDAT;
               end
            end
            crm_pkg::H_RDAT: begin
               if (rsp_take && LNK.rsp_ctrl && LNK.rsp_byte == `CRM_TOK_END) begin
                  RES_VALID <= 1'b1;
                  RES_OK    <= ok_r;
                  state_r   <= crm_pkg::H_IDLE;
               end else if (rsp_take && !LNK.rsp_ctrl) begin
                  RES_DATA <= {RES_DATA[23:0], LNK.rsp_byte};
               end
            end
            default: state_r <= crm_pkg::H_IDLE;
         endcase
      end
   end

   // processor-status resource id, register number shifted past the type byte
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         PS_ID <= 32'h00000000;
      else
         PS_ID <= {PS_REG, `CRM_PS_LOW};
   end
endmodule : crm_host
`default_nettype wire

/* File: bench/crm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module crm_monitor (
   input wire logic        CLK,
   input wire logic        ARST_N,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        req_ctrl,
   input wire logic [7:0]  req_byte,
   input wire logic [31:0] req_dest,
   input wire logic        rsp_valid,
   input wire logic        rsp_ready,
   input wire logic        rsp_ctrl,
   input wire logic [7:0]  rsp_byte,
   input wire logic [23:0] rsp_dest
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   logic        act_r;
   logic [7:0]  hdr_r;
   logic [3:0]  cnt_r;
   logic [23:0] ret_r;
   wire logic   tk  = req_valid && req_ready;
   wire logic   fin = tk && act_r && req_ctrl && req_byte == 8'h01;
   wire logic   sup = (hdr_r == 8'hC0 || hdr_r == 8'h24) && ret_r[7:0] == 8'hFF;
   ////////////////////////////////////////////////////////////////////////////////
   // message tracker; the idle device drops a lone closing token, so it is ignored
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         act_r <= 1'b0;
         hdr_r <= 8'h00;
         cnt_r <= 4'h0;
         ret_r <= 24'h000000;
      end else if (tk && !act_r && req_ctrl && req_byte != 8'h01) begin
         act_r <= 1'b1;
         hdr_r <= req_byte;
         cnt_r <= 4'h0;
      end else if (tk && act_r) begin
         act_r <= !fin;
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r < 4'h3) ret_r <= {ret_r[15:0], req_byte};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   req_hold_a: assert property (req_valid && !req_ready |=> req_valid &&
      $stable(req_byte) && $stable(req_ctrl)) else $error("request byte not held");
   dest_hold_a: assert property (tk && act_r && !fin |=> $stable(req_dest))
      else $error("destination moved inside a message");
   reply_due_a: assert property (fin && !sup |=> rsp_valid && rsp_ctrl &&
      (rsp_byte == 8'h03 || rsp_byte == 8'h04)) else $error("reply header missing");
   no_reply_a: assert property (fin && sup |=> !rsp_valid [*4])
      else $error("reply sent for suppressed write");
   ret_echo_a: assert property (rsp_valid |-> rsp_dest == ret_r)
      else $error("reply sent to wrong return id");
   nak_close_a: assert property (rsp_valid && rsp_ready && rsp_ctrl &&
      rsp_byte == 8'h04 |=> rsp_valid && rsp_ctrl && rsp_byte == 8'h01) else $error("bad nak");
   busy_refuse_a: assert property (rsp_valid |-> !req_ready)
      else $error("request taken while replying");
   word_read_a: assert property (rsp_valid && rsp_ready && rsp_ctrl && rsp_byte == 8'h03 &&
      hdr_r == 8'hC1 |=> (rsp_valid && !rsp_ctrl) [*4] ##1 rsp_valid && rsp_ctrl &&
      rsp_byte == 8'h01) else $error("word read reply malformed");
   hdr_first_a: assert property ($rose(rsp_valid) |-> rsp_ctrl && rsp_byte != 8'h01)
      else $error("reply does not open with a status token");
endmodule : crm_monitor
`default_nettype wire

/* File: bench/crm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module crm_tb;
   localparam logic [15:0] TID = 16'h0011; // arbitrary
   localparam logic [15:0] NID = 16'h0022; // arbitrary
   localparam logic [7:0]  PID = 8'h33;    // arbitrary
   logic        CLK, ARST_N, cv, cr, cw, rv, rok;
   logic [1:0]  ct, t;
   logic [15:0] cid, creg;
   logic [7:0]  csz;
   logic [23:0] cret, psr;
   logic [31:0] cdat, rdat, psid, rng, r, wd;
   logic [1:0]  wt;
   logic [15:0] wg;
   logic [31:0] tm [16];
   logic [31:0] nm [16];
   logic [7:0]  pm [16];
   int          n_fail, n_compared;
   crm_if lnk ();
   crm_dev #(.TILE_ID(TID), .NODE_ID(NID), .PERIPH_ID(PID)) crm_dev_i (.CLK(CLK),
      .ARST_N(ARST_N), .LNK(lnk), .WR_STB(), .WR_TGT(wt), .WR_REG(wg), .WR_DATA(wd));
   crm_host crm_host_i (.CLK(CLK), .ARST_N(ARST_N), .LNK(lnk), .CMD_VALID(cv),
      .CMD_READY(cr), .CMD_WR(cw), .CMD_TGT(ct), .CMD_ID(cid), .CMD_PER(PID),
      .CMD_RET(cret), .CMD_REG(creg), .CMD_SIZE(csz), .CMD_DATA(cdat), .RES_VALID(rv),
      .RES_OK(rok), .RES_DATA(rdat), .PS_REG(psr), .PS_ID(psid));
   crm_monitor crm_monitor_i (.CLK(CLK), .ARST_N(ARST_N), .req_valid(lnk.req_valid),
      .req_ready(lnk.req_ready), .req_ctrl(lnk.req_ctrl), .req_byte(lnk.req_byte),
      .req_dest(lnk.req_dest), .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready),
      .rsp_ctrl(lnk.rsp_ctrl), .rsp_byte(lnk.rsp_byte), .rsp_dest(lnk.rsp_dest));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   task automatic close_out;
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // model kept in step with the device; entered just after a clock edge
   task automatic cmd(input logic w, input logic [1:0] tg, input logic [15:0] id,
                      input logic [15:0] rg, input logic [7:0] sz, input logic [23:0] rt);
      logic        ok;
      logic [31:0] ex, d, m;
      int          k;
      d = xs();
      ex = 32'h0;
      ok = id == (tg == 2'b01 ? TID : NID) && (tg == 2'b11 ? sz inside {[1:4]} &&
           rg + sz <= 16 : rg < 16);
      if (ok && tg == 2'b11) begin
         for (k = 0; k < sz; k++) begin
            if (w) pm[rg[3:0] + k[3:0]] = 8'(d >> (8 * (sz - 1 - k)));
            ex = {ex[23:0], pm[rg[3:0] + k[3:0]]};
         end
      end else if (ok) begin
         if (w && tg == 2'b01) tm[rg[3:0]] = d;
         if (w && tg == 2'b10) nm[rg[3:0]] = d;
         ex = tg == 2'b01 ? tm[rg[3:0]] : nm[rg[3:0]];
      end
      m = 32'hFFFFFFFF >> (8 * (tg == 2'b11 ? 4 - int'(sz) : 0));
      {cv, cw, ct, cid, creg, csz, cret, cdat, psr} = {1'b1, w, tg, id, rg, sz, rt, d, d[23:0]};
      @(posedge CLK);
      #2 cv = 1'b0;
      chk(psid, {psr, 8'h0B});
      for (k = 0; k < 60 && rv !== 1'b1; k++) begin
         @(posedge CLK);
         #2;
      end
      chk({31'h0, rv}, 32'h1);
      if (rv !== 1'b1) close_out;
      chk({31'h0, rok}, {31'h0, ok || (w && rt[7:0] == 8'hFF)});
      if (ok && !w) chk(rdat & m, ex);
      if (ok && w) chk(wd, tg == 2'b11 ? {24'h000000, d[7:0]} : d);
      if (ok && w) chk({14'h0000, wt, wg}, {14'h0000, tg, tg == 2'b11 ? rg + 16'(sz) - 16'h0001 : rg});
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   initial begin
      {ARST_N, cv, cw, ct, cid, creg, csz, cret, cdat, psr} = '0;
      {n_fail, n_compared, rng} = {32'h0, 32'h0, 32'h45};
      for (int i = 0; i < 16; i++) {tm[i], nm[i], pm[i]} = '0;
      repeat (2) @(posedge CLK);
      #2 ARST_N = 1'b1;
      cmd(1'b1, 2'b01, TID, 16'h000F, 8'h00, 24'hABCD12);
      cmd(1'b0, 2'b01, TID, 16'h000F, 8'h00, 24'h00FF01);
      cmd(1'b1, 2'b10, NID, 16'h0010, 8'h00, 24'h123456);
      cmd(1'b1, 2'b11, NID, 16'h000C, 8'h04, 24'h0000FF);
      cmd(1'b0, 2'b11, NID, 16'h000C, 8'h04, 24'h777777);
      cmd(1'b0, 2'b11, NID, 16'h000D, 8'h04, 24'h777778);
      cmd(1'b1, 2'b01, NID, 16'h0001, 8'h00, 24'h5555FF);
      repeat (80) begin
         r = xs();
         t = r[2:1] == 2'b00 ? 2'b11 : r[2:1];
         cmd(r[0], t, r[6:5] == 2'b11 ? 16'h0BAD : (t == 2'b01 ? TID : NID),
             {11'h0, r[12:8]}, 8'(r[15:13] % 3'd5), r[7] ? {r[31:16], 8'hFF} : r[31:8]);
      end
      close_out;
   end
endmodule : crm_tb
`default_nettype wire
